// ### rtl/fcdmac_pkg.sv
// constants and types of the four-channel dma controller
package fcdmac_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_PER = 5;
    // per-channel register offsets, channel in address bits 6:5
    localparam logic [4:0] OFF_SRC = 5'h00;
    localparam logic [4:0] OFF_DST = 5'h04;
    localparam logic [4:0] OFF_LEN = 5'h08;
    localparam logic [4:0] OFF_THR = 5'h0C;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_IDX = 5'h14;
    // global register offsets
    localparam logic [7:0] OFF_ROUTE = 8'h80;
    localparam logic [7:0] OFF_STAT = 8'h84;
    localparam logic [7:0] OFF_FRZ_SET = 8'h88;
    localparam logic [7:0] OFF_FRZ_CLR = 8'h8C;
    // channel_control fields, then the freeze register bit
    localparam int CTL_ON = 0;
    localparam int CTL_WID = 1;
    localparam int CTL_SINC = 3;
    localparam int CTL_DINC = 4;
    localparam int CTL_TRIG = 5;
    localparam int CTL_AUTO = 6;
    localparam int CTL_PRIO = 7;
    localparam int CTL_YIELD = 10;
    localparam int CTL_FILL = 11;
    localparam int CTL_EDGE = 12;
    localparam int CTL_IRQEN = 13;
    localparam int FRZ_BIT = 4;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [31:0] ADDR_RST = 32'h00000000;
    localparam logic [2:0] SEL_NONE = 3'h7;
    localparam logic [5:0] ROUTE_RST = {SEL_NONE, SEL_NONE};
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_RD = 4'h2,
        ST_WR = 4'h4,
        ST_DONE = 4'h8
    } fcdmac_state_type;
endpackage : fcdmac_pkg

// ### rtl/fcdmac_top.sv
// four-channel dma controller
`timescale 1ns/100ps
module fcdmac_top
    import fcdmac_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_core_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_bus_req,
    output logic o_bus_we,
    output logic [31:0] o_bus_addr,
    output logic [31:0] o_bus_wdata,
    output logic [1:0] o_bus_size,
    input wire logic i_bus_ack,
    input wire logic [31:0] i_bus_rdata,
    input wire logic [4:0] i_per_rx_req,
    input wire logic [4:0] i_per_tx_req,
    output logic [4:0] o_per_rx_ack,
    output logic [4:0] o_per_tx_ack,
    output logic [3:0] o_chan_irq
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] src_reg [NUM_CH];
    logic [31:0] dst_reg [NUM_CH];
    logic [15:0] len_reg [NUM_CH];
    logic [15:0] thr_reg [NUM_CH];
    logic [15:0] ctrl_reg [NUM_CH];
    logic [15:0] idx_reg [NUM_CH];
    logic [5:0] route_reg;
    logic [3:0] stat_reg;
    logic frz_reg;
    logic [3:0] req_prev_reg;
    logic [3:0] pend_reg;
    fcdmac_state_type state_reg;
    logic [1:0] cur_reg;
    logic own_reg;

    function automatic logic [31:0] addr_of(input logic [31:0] base, input logic [15:0] idx,
                                            input logic inc, input logic [1:0] wid);
        addr_of = inc ? base + ({16'h0000, idx} << wid) : base;
    endfunction : addr_of

    // ----------------------------------------
    // request routing
    // ----------------------------------------
    logic [2:0] sel_lo;
    logic [2:0] sel_hi;
    logic val_lo;
    logic val_hi;
    logic [3:0] ch_req;
    logic [3:0] req_eff;
    logic [3:0] ready_v;
    assign sel_lo = route_reg[2:0];
    assign sel_hi = route_reg[5:3];
    assign val_lo = sel_lo < 3'(NUM_PER);
    assign val_hi = (sel_hi < 3'(NUM_PER)) && !(val_lo && sel_hi == sel_lo);
    // rx to even channels, tx to odd; lower selector to channels 0-1, higher to 2-3
    assign ch_req[0] = val_lo && i_per_rx_req[sel_lo];
    assign ch_req[1] = val_lo && i_per_tx_req[sel_lo];
    assign ch_req[2] = val_hi && i_per_rx_req[sel_hi];
    assign ch_req[3] = val_hi && i_per_tx_req[sel_hi];

    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            req_eff[c] = ctrl_reg[c][CTL_EDGE] ? pend_reg[c] : ch_req[c];
            ready_v[c] = ctrl_reg[c][CTL_ON] && (!ctrl_reg[c][CTL_TRIG] || req_eff[c])
                && (!frz_reg || (own_reg && cur_reg == 2'(c)));
        end
    end

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    logic found;
    logic [1:0] best;
    logic [2:0] best_prio;
    logic [2:0] cur_prio;
    logic keep;
    logic go;
    logic [1:0] pick;
    assign cur_prio = ctrl_reg[cur_reg][CTL_PRIO +: 3];

    // highest priority, lower channel on ties
    always_comb
    begin
        found = 1'b0;
        best = 2'b00;
        best_prio = 3'h0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (ready_v[c] && (!found || ctrl_reg[c][CTL_PRIO +: 3] > best_prio))
            begin
                found = 1'b1;
                best = 2'(c);
                best_prio = ctrl_reg[c][CTL_PRIO +: 3];
            end
        end
    end

    assign keep = own_reg && ready_v[cur_reg] && (ctrl_reg[cur_reg][CTL_FILL]
        || !ctrl_reg[cur_reg][CTL_YIELD] || !found || best_prio <= cur_prio);
    assign pick = keep ? cur_reg : best;
    assign go = i_core_ce && state_reg == ST_IDLE && (keep || found);

    // ----------------------------------------
    // end of item
    // ----------------------------------------
    logic fin;
    logic at_len;
    logic hit_thr;
    logic cur_trig;
    assign fin = i_core_ce && state_reg == ST_DONE;
    assign at_len = idx_reg[cur_reg] == len_reg[cur_reg];
    assign hit_thr = idx_reg[cur_reg] == thr_reg[cur_reg];
    assign cur_trig = ctrl_reg[cur_reg][CTL_TRIG];

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cur_reg <= 2'b00;
            own_reg <= 1'b0;
            o_bus_req <= 1'b0;
            o_bus_we <= 1'b0;
            o_bus_addr <= ADDR_RST;
            o_bus_wdata <= ADDR_RST;
            o_bus_size <= 2'b00;
        end
        else if (i_core_ce)
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        cur_reg <= pick;
                        own_reg <= !ctrl_reg[pick][CTL_TRIG];
                        o_bus_req <= 1'b1;
                        o_bus_we <= 1'b0;
                        o_bus_size <= ctrl_reg[pick][CTL_WID +: 2];
                        o_bus_addr <= addr_of(src_reg[pick], idx_reg[pick],
                            ctrl_reg[pick][CTL_SINC], ctrl_reg[pick][CTL_WID +: 2]);
                        state_reg <= ST_RD;
                    end
                end
                ST_RD:
                begin
                    if (i_bus_ack)
                    begin
                        o_bus_we <= 1'b1;
                        o_bus_wdata <= i_bus_rdata;
                        o_bus_addr <= addr_of(dst_reg[cur_reg], idx_reg[cur_reg],
                            ctrl_reg[cur_reg][CTL_DINC], ctrl_reg[cur_reg][CTL_WID +: 2]);
                        state_reg <= ST_WR;
                    end
                end
                ST_WR:
                begin
                    if (i_bus_ack)
                    begin
                        o_bus_req <= 1'b0;
                        o_bus_we <= 1'b0;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    if (at_len)
                    begin
                        own_reg <= 1'b0;
                    end
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // acknowledges and interrupt pulses
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_per_rx_ack <= 5'h00;
            o_per_tx_ack <= 5'h00;
            o_chan_irq <= 4'h0;
        end
        else if (i_core_ce)
        begin
            o_per_rx_ack <= 5'h00;
            o_per_tx_ack <= 5'h00;
            o_chan_irq <= 4'h0;
            if (state_reg == ST_WR && i_bus_ack && cur_trig)
            begin
                if (!cur_reg[1] && val_lo)
                begin
                    o_per_rx_ack[sel_lo] <= !cur_reg[0];
                    o_per_tx_ack[sel_lo] <= cur_reg[0];
                end
                if (cur_reg[1] && val_hi)
                begin
                    o_per_rx_ack[sel_hi] <= !cur_reg[0];
                    o_per_tx_ack[sel_hi] <= cur_reg[0];
                end
            end
            if (state_reg == ST_DONE && hit_thr && ctrl_reg[cur_reg][CTL_IRQEN])
            begin
                o_chan_irq[cur_reg] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // edge capture
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_prev_reg <= 4'h0;
            pend_reg <= 4'h0;
        end
        else if (i_core_ce)
        begin
            req_prev_reg <= ch_req;
            for (int c = 0; c < NUM_CH; c++)
            begin
                pend_reg[c] <= (ch_req[c] && !req_prev_reg[c])
                    || (pend_reg[c] && !(go && pick == 2'(c)));
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic ch_sel;
    logic [1:0] wch;
    logic [4:0] woff;
    assign ch_sel = !i_reg_addr[7];
    assign wch = i_reg_addr[6:5];
    assign woff = i_reg_addr[4:0];

    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                src_reg[c] <= ADDR_RST;
                dst_reg[c] <= ADDR_RST;
                len_reg[c] <= CNT_RST;
                thr_reg[c] <= CNT_RST;
                ctrl_reg[c] <= CTRL_RST;
                idx_reg[c] <= CNT_RST;
            end
            route_reg <= ROUTE_RST;
            stat_reg <= 4'h0;
            frz_reg <= 1'b0;
        end
        else if (i_core_ce)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (fin && cur_reg == 2'(c))
                begin
                    idx_reg[c] <= at_len ? CNT_RST : idx_reg[c] + 16'h0001;
                    if (at_len && (!cur_trig || !ctrl_reg[c][CTL_AUTO]))
                    begin
                        ctrl_reg[c][CTL_ON] <= 1'b0;
                    end
                end
                if (i_reg_wr && ch_sel && wch == 2'(c))
                begin
                    if (woff == OFF_SRC)
                        src_reg[c] <= i_reg_wdata;
                    if (woff == OFF_DST)
                        dst_reg[c] <= i_reg_wdata;
                    if (woff == OFF_LEN)
                        len_reg[c] <= i_reg_wdata[15:0];
                    if (woff == OFF_THR)
                        thr_reg[c] <= i_reg_wdata[15:0];
                    if (woff == OFF_CTRL)
                    begin
                        ctrl_reg[c] <= i_reg_wdata[15:0];
                        if (i_reg_wdata[CTL_ON] && !ctrl_reg[c][CTL_ON])
                            idx_reg[c] <= CNT_RST;
                    end
                end
            end
            if (i_reg_wr && i_reg_addr == OFF_ROUTE)
                route_reg <= i_reg_wdata[5:0];
            if (i_reg_wr && i_reg_addr == OFF_FRZ_SET && i_reg_wdata[FRZ_BIT])
                frz_reg <= 1'b1;
            else if (i_reg_wr && i_reg_addr == OFF_FRZ_CLR && i_reg_wdata[FRZ_BIT])
                frz_reg <= 1'b0;
            stat_reg <= (stat_reg & ~((i_reg_wr && i_reg_addr == OFF_STAT)
                ? i_reg_wdata[3:0] : 4'h0))
                | ((fin && hit_thr && ctrl_reg[cur_reg][CTL_IRQEN])
                ? (4'h1 << cur_reg) : 4'h0);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_reg_rdata <= ADDR_RST;
        else if (i_core_ce)
        begin
            o_reg_rdata <= ADDR_RST;
            if (i_reg_rd && ch_sel)
            begin
                unique case (woff)
                    OFF_SRC: o_reg_rdata <= src_reg[wch];
                    OFF_DST: o_reg_rdata <= dst_reg[wch];
                    OFF_LEN: o_reg_rdata <= {16'h0000, len_reg[wch]};
                    OFF_THR: o_reg_rdata <= {16'h0000, thr_reg[wch]};
                    OFF_CTRL: o_reg_rdata <= {16'h0000, ctrl_reg[wch]};
                    OFF_IDX: o_reg_rdata <= {16'h0000, idx_reg[wch]};
                    default: o_reg_rdata <= ADDR_RST;
                endcase
            end
            else if (i_reg_rd && i_reg_addr == OFF_ROUTE)
                o_reg_rdata <= {26'h0, route_reg};
            else if (i_reg_rd && i_reg_addr == OFF_STAT)
                o_reg_rdata <= {28'h0000000, stat_reg};
            else if (i_reg_rd && i_reg_addr == OFF_FRZ_SET)
                o_reg_rdata <= 32'(frz_reg) << FRZ_BIT;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_irq_pulse: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        fin && hit_thr && ctrl_reg[cur_reg][CTL_IRQEN] |=> o_chan_irq == (4'h1 << $past(cur_reg)))
        else $error("threshold hit without interrupt pulse");
    chk_idx_wrap: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        fin && at_len && cur_trig && ctrl_reg[cur_reg][CTL_AUTO] && !i_reg_wr
        |=> idx_reg[cur_reg] == CNT_RST && ctrl_reg[cur_reg][CTL_ON])
        else $error("auto restart did not rewind");
    chk_on_stop: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        fin && at_len && !cur_trig && !i_reg_wr |=> !ctrl_reg[cur_reg][CTL_ON])
        else $error("on bit not cleared at end");
    chk_idx_step: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        fin && !at_len && !i_reg_wr
        |=> idx_reg[cur_reg] == $past(idx_reg[cur_reg]) + 16'h0001)
        else $error("index did not step by one");
    chk_src_addr: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        go |=> o_bus_req && !o_bus_we && o_bus_addr == addr_of(src_reg[cur_reg],
        idx_reg[cur_reg], ctrl_reg[cur_reg][CTL_SINC], ctrl_reg[cur_reg][CTL_WID +: 2]))
        else $error("source address wrong");
    chk_wait_req: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        go && ctrl_reg[pick][CTL_TRIG] |-> req_eff[pick])
        else $error("triggered channel started without request");
    chk_freeze_hold: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        go && frz_reg |-> own_reg && pick == cur_reg && !ctrl_reg[pick][CTL_TRIG])
        else $error("frozen channel granted");
    chk_fill_lock: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        go && own_reg && ready_v[cur_reg] && ctrl_reg[cur_reg][CTL_FILL] |-> pick == cur_reg)
        else $error("memory fill channel preempted");
    chk_route_prec: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        val_lo && sel_hi == sel_lo |-> ch_req[3:2] == 2'b00)
        else $error("duplicate selector routed twice");
endmodule : fcdmac_top

// ### sim/fcdmac_mem_model.sv
// memory model on the far side of the dma bus
`timescale 1ns/100ps
module fcdmac_mem_model
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [1:0] i_size,
    input wire logic [3:0] i_delay,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [3:0] cnt_reg;
    logic [31:0] wa [0:15];
    logic [31:0] wd [0:15];
    logic [1:0] ws [0:15];
    int n_wr;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_ack <= 1'b0;
            cnt_reg <= 4'h0;
            o_rdata <= 32'h0;
            n_wr <= 0;
        end
        else
        begin
            o_ack <= 1'b0;
            cnt_reg <= 4'h0;
            // data lines change every cycle outside an answer
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack && cnt_reg < i_delay)
                cnt_reg <= cnt_reg + 4'h1;
            else if (i_req && !o_ack)
            begin
                o_ack <= 1'b1;
                o_rdata <= {16'hC3A5, i_addr[15:0]};
                if (i_we)
                begin
                    wa[n_wr % 16] <= i_addr;
                    wd[n_wr % 16] <= i_wdata;
                    ws[n_wr % 16] <= i_size;
                    n_wr <= n_wr + 1;
                end
            end
        end
    end
endmodule : fcdmac_mem_model

// ### sim/fcdmac_top_test.sv
// self-checking bench of the four-channel dma controller
`timescale 1ns/100ps
module fcdmac_top_test
    import fcdmac_pkg::*;
;
    logic clk;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] rx_req = 5'h00;
    logic [4:0] tx_req = 5'h00;
    logic [3:0] delay = 4'h0;
    logic [31:0] rdata, bus_addr, bus_wdata, brdata;
    logic bus_req, bus_we, ack;
    logic [1:0] bus_size;
    logic [4:0] rx_ack, tx_ack;
    logic [3:0] irq;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int irq_n = 0;
    int rxa_n = 0;
    int txa_n = 0;
    fcdmac_top dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_core_ce(1'b1),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_bus_req(bus_req), .o_bus_we(bus_we),
        .o_bus_addr(bus_addr), .o_bus_wdata(bus_wdata), .o_bus_size(bus_size),
        .i_bus_ack(ack), .i_bus_rdata(brdata), .i_per_rx_req(rx_req),
        .i_per_tx_req(tx_req), .o_per_rx_ack(rx_ack), .o_per_tx_ack(tx_ack),
        .o_chan_irq(irq));
    fcdmac_mem_model mem_u (.i_clk(clk), .i_rstn(rstn), .i_req(bus_req),
        .i_we(bus_we), .i_addr(bus_addr), .i_wdata(bus_wdata), .i_size(bus_size),
        .i_delay(delay),
        .o_ack(ack), .o_rdata(brdata));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        irq_n <= irq_n + int'(irq[0] === 1'b1);
        rxa_n <= rxa_n + int'(rx_ack[2] === 1'b1);
        txa_n <= txa_n + int'(tx_ack[2] === 1'b1);
        if (cyc == 30000)
        begin
            errors++;
            final_report();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [4:0] off);
        ra = {1'b0, ch, off};
    endfunction : ra
    function automatic logic [31:0] mk(input logic [1:0] w, input logic s, input logic d,
        input logic t, input logic e, input logic [2:0] p);
        mk = 32'h1 | 32'(w) << CTL_WID | 32'(s) << CTL_SINC | 32'(d) << CTL_DINC
            | 32'(t) << CTL_TRIG | 32'(e) << CTL_EDGE | 32'(p) << CTL_PRIO | 32'h1 << CTL_IRQEN;
    endfunction : mk
    task automatic setup(input logic [1:0] ch, input logic [31:0] s, input logic [31:0] d,
        input logic [15:0] len, input logic [15:0] thr, input logic [31:0] ctl);
        reg_wr(ra(ch, OFF_SRC), s);
        reg_wr(ra(ch, OFF_DST), d);
        reg_wr(ra(ch, OFF_LEN), {16'h0, len});
        reg_wr(ra(ch, OFF_THR), {16'h0, thr});
        reg_wr(ra(ch, OFF_CTRL), ctl);
    endtask : setup
    task automatic wait_off(input logic [1:0] ch);
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < 300 && d[0] !== 1'b0; i++)
            reg_rd(ra(ch, OFF_CTRL), d);
        check(d & 32'h1, 32'h0);
    endtask : wait_off
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_regs();
        logic [31:0] d;
        reg_rd(ra(2'h3, OFF_CTRL), d);
        check(d, 32'h0);
        reg_rd(OFF_ROUTE, d);
        check(d, 32'h3F);
        reg_rd(8'hFC, d);
        check(d, 32'h0);
        reg_wr(ra(2'h1, OFF_THR), 32'hFFFFFFFF);
        reg_rd(ra(2'h1, OFF_THR), d);
        check(d, 32'h0000FFFF);
        reg_wr(ra(2'h1, OFF_IDX), 32'h34);
        reg_rd(ra(2'h1, OFF_IDX), d);
        check(d, 32'h0);
    endtask : s_regs
    task automatic s_copy(input logic [1:0] w, input logic [15:0] len, input logic [15:0] thr);
        int b;
        int q;
        logic [31:0] d;
        b = mem_u.n_wr;
        q = irq_n;
        setup(2'h0, 32'h100, 32'h400, len, thr, mk(w, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0));
        wait_off(2'h0);
        check(32'(mem_u.n_wr - b), 32'(len) + 32'h1);
        for (int i = 0; i <= int'(len); i++)
        begin
            check(mem_u.wa[(b + i) % 16], 32'h400 + (32'(i) << w));
            check(32'(mem_u.ws[(b + i) % 16]), 32'(w));
            if (w == 2'h2)
                check(mem_u.wd[(b + i) % 16], {16'hC3A5, 16'h100 + 16'(i * 4)});
        end
        check(32'(irq_n - q), 32'h1);
        reg_rd(OFF_STAT, d);
        check(d, 32'h1);
        reg_wr(OFF_STAT, 32'h1);
        reg_rd(OFF_STAT, d);
        check(d, 32'h0);
    endtask : s_copy
    task automatic s_rx();
        int b;
        int q;
        logic [31:0] d;
        b = mem_u.n_wr;
        q = rxa_n;
        reg_wr(OFF_ROUTE, 32'h12);
        setup(2'h2, 32'h40, 32'h800, 16'h0, 16'h5, mk(2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0));
        setup(2'h0, 32'h50, 32'h600, 16'h1, 16'h5, mk(2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0));
        repeat (20) @(posedge clk);
        check(32'(mem_u.n_wr - b), 32'h0);
        rx_req <= 5'h04;
        wait_off(2'h0);
        rx_req <= 5'h00;
        check(32'(mem_u.n_wr - b), 32'h2);
        check(mem_u.wa[(b + 1) % 16], 32'h604);
        check(32'(rxa_n - q), 32'h2);
        reg_rd(ra(2'h2, OFF_CTRL), d);
        check(d & 32'h1, 32'h1);
        reg_wr(ra(2'h2, OFF_CTRL), 32'h0);
    endtask : s_rx
    task automatic s_edge_tx();
        int b;
        int q;
        b = mem_u.n_wr;
        q = txa_n;
        delay <= 4'h2;
        setup(2'h1, 32'h60, 32'h700, 16'h1, 16'h5, mk(2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0));
        tx_req <= 5'h04;
        repeat (40) @(posedge clk);
        check(32'(mem_u.n_wr - b), 32'h1);
        check(32'(txa_n - q), 32'h1);
        tx_req <= 5'h00;
        repeat (2) @(posedge clk);
        tx_req <= 5'h04;
        wait_off(2'h1);
        tx_req <= 5'h00;
        check(32'(mem_u.n_wr - b), 32'h2);
        delay <= 4'h0;
    endtask : s_edge_tx
    task automatic s_auto();
        int b;
        logic [31:0] d;
        b = mem_u.n_wr;
        setup(2'h0, 32'h50, 32'h300, 16'h1, 16'h9, mk(2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0)
            | 32'h1 << CTL_AUTO);
        repeat (3)
        begin
            rx_req <= 5'h04;
            repeat (12) @(posedge clk);
            rx_req <= 5'h00;
            repeat (2) @(posedge clk);
        end
        check(32'(mem_u.n_wr - b), 32'h3);
        check(mem_u.wa[(b + 2) % 16], 32'h300);
        reg_rd(ra(2'h0, OFF_CTRL), d);
        check(d & 32'h1, 32'h1);
        reg_rd(ra(2'h0, OFF_IDX), d);
        check(d, 32'h1);
        reg_wr(ra(2'h0, OFF_CTRL), 32'h0);
    endtask : s_auto
    task automatic s_preempt(input logic fill);
        int b;
        b = mem_u.n_wr;
        setup(2'h3, 32'h100, 32'hA00, 16'h0, 16'h0, 32'h0);
        setup(2'h0, 32'h100, 32'h900, 16'h3, 16'h9, mk(2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1)
            | 32'h1 << CTL_YIELD | 32'(fill) << CTL_FILL);
        reg_wr(ra(2'h3, OFF_CTRL), mk(2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5));
        wait_off(2'h0);
        wait_off(2'h3);
        check(32'(mem_u.n_wr - b), 32'h5);
        if (fill)
            check(mem_u.wa[(b + 4) % 16], 32'hA00);
        else
            check(mem_u.wa[(b + 1) % 16], 32'hA00);
    endtask : s_preempt
    task automatic s_freeze_prio();
        int b;
        logic [31:0] d;
        b = mem_u.n_wr;
        setup(2'h1, 32'h100, 32'hB00, 16'h3, 16'h9, mk(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0));
        reg_wr(OFF_FRZ_SET, 32'h10);
        wait_off(2'h1);
        check(32'(mem_u.n_wr - b), 32'h4);
        b = mem_u.n_wr;
        reg_rd(OFF_FRZ_SET, d);
        check(d & 32'h10, 32'h10);
        setup(2'h0, 32'h100, 32'h900, 16'h0, 16'h0, mk(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1));
        setup(2'h3, 32'h100, 32'hA00, 16'h0, 16'h0, mk(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 3'h5));
        repeat (20) @(posedge clk);
        check(32'(mem_u.n_wr - b), 32'h0);
        reg_wr(OFF_FRZ_CLR, 32'h10);
        wait_off(2'h0);
        wait_off(2'h3);
        check(mem_u.wa[b % 16], 32'hA00);
        check(mem_u.wa[(b + 1) % 16], 32'h900);
    endtask : s_freeze_prio
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        s_regs();
        s_copy(2'h0, 16'h1, 16'h1);
        s_copy(2'h1, 16'h1, 16'h0);
        s_copy(2'h2, 16'h2, 16'h2);
        s_copy(2'h2, 16'h0, 16'h0);
        s_rx();
        s_edge_tx();
        s_auto();
        s_preempt(1'b0);
        s_preempt(1'b1);
        s_freeze_prio();
        final_report();
    end
endmodule : fcdmac_top_test
